/* File: core/ifp_pkg.sv */
// Shared constants and types of the instruction fetch pipeline.
package ifp_pkg;

   localparam int          IFP_PC_W        = 21;
   localparam int          IFP_WORD_W      = 16;
   localparam int          IFP_DATA_W      = 8;
   localparam int          IFP_ADDR_W      = 12;
   localparam int          IFP_QPHASES     = 4;
   localparam logic [1:0]  IFP_Q_FETCH     = 2'h0;
   localparam logic [1:0]  IFP_Q_READ      = 2'h1;
   localparam logic [1:0]  IFP_Q_EXEC      = 2'h2;
   localparam logic [1:0]  IFP_Q_WRITE     = 2'h3;
   localparam logic [20:0] IFP_PC_RESET    = 21'h000000;
   localparam logic [20:0] IFP_PC_STEP     = 21'h000002;
   localparam logic [15:0] IFP_NOP_WORD    = 16'h0000;
   localparam logic [3:0]  IFP_CONT_TAG    = 4'hF;
   localparam logic [7:0]  IFP_OP_ABSJ     = 8'hEF;
   localparam logic [4:0]  IFP_OP_RELJ     = 5'h1A;
   localparam logic [5:0]  IFP_OP_MUL      = 6'h01;
   localparam logic [7:0]  IFP_OP_MOVLW    = 8'h0E;
   localparam logic [3:0]  IFP_OP_STALL    = 4'h0;
   localparam logic [7:0]  IFP_STALL_CODE  = 8'h0F;

   typedef enum logic [1:0] {
      IFP_RUN,
      IFP_ABS_WAIT,
      IFP_FLUSH,
      IFP_HOLD
   } ifp_state_e;

endpackage

/* File: core/ifp_phase_counter.sv */
// Divides the oscillator clock into four phases of one instruction cycle.
`timescale 1ns/10ps
module ifp_phase_counter #(
   parameter int PHASES = 4
) (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Phase outputs.
   output logic [1:0]      phase,
   output logic            cycle_end
);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 2'h0;
      end else if (phase == 2'(PHASES - 1)) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign cycle_end = (phase == 2'(PHASES - 1));
endmodule

/* File: core/ifp_multiplier.sv */
// Unsigned eight by eight multiplier producing a sixteen-bit product.
`timescale 1ns/10ps
module ifp_multiplier #(
   parameter int W = 8
) (
   // Operands.
   input  wire logic [W-1:0]   factor_a,
   input  wire logic [W-1:0]   factor_b,
   // Result.
   output logic [2*W-1:0]      product
);
   assign product = {{W{1'b0}}, factor_a} * {{W{1'b0}}, factor_b};
endmodule

/* File: core/ifp_core.sv */
// Fetch and execute pipeline with jump handling and hardware multiply.
`timescale 1ns/10ps
module ifp_core
   import ifp_pkg::*;
#(
   parameter int STALL_CYCLES = 1
) (
   // Clock and reset.
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   // Program memory, byte wide.
   output logic [ifp_pkg::IFP_PC_W-1:0]       prog_addr,
   input  wire logic [ifp_pkg::IFP_DATA_W-1:0] prog_rdata,
   // Data memory.
   output logic [ifp_pkg::IFP_ADDR_W-1:0]     data_addr,
   output logic                               data_rd,
   input  wire logic [ifp_pkg::IFP_DATA_W-1:0] data_rdata,
   output logic                               data_wr,
   output logic [ifp_pkg::IFP_DATA_W-1:0]     data_wdata,
   // Datapath view.
   output logic [ifp_pkg::IFP_PC_W-1:0]       program_counter,
   output logic [ifp_pkg::IFP_WORD_W-1:0]     instruction_holding_register,
   output logic [ifp_pkg::IFP_DATA_W-1:0]     working_register,
   output logic [ifp_pkg::IFP_DATA_W-1:0]     product_high_byte,
   output logic [ifp_pkg::IFP_DATA_W-1:0]     product_low_byte,
   output logic [1:0]                         phase,
   output logic                               fetch_hold
);
   import ifp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]              q;
   logic                    cycle_end;
   logic [IFP_WORD_W-1:0]   fetch_word;
   logic [IFP_DATA_W-1:0]   fetch_low;
   logic                    prev_multi;
   logic [IFP_DATA_W-1:0]   operand;
   logic [2*IFP_DATA_W-1:0] product;
   logic [IFP_PC_W-1:0]     exec_pc;
   logic [7:0]              hold_count;
   ifp_state_e              state;
   logic                    is_absj;
   logic                    is_relj;
   logic                    is_mul;
   logic                    is_movlw;
   logic                    is_stall;
   logic                    is_lone_cont;
   logic                    exec_valid;
   logic [IFP_PC_W-1:0]     next_target;
   logic [IFP_PC_W-1:0]     rel_disp;
   logic [IFP_PC_W-1:0]     abs_target;

   ifp_phase_counter #(
      .PHASES    (IFP_QPHASES)
   ) u_phase (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .phase     (q),
      .cycle_end (cycle_end)
   );

   ifp_multiplier #(
      .W         (IFP_DATA_W)
   ) u_mul (
      .factor_a  (working_register),
      .factor_b  (operand),
      .product   (product)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the held word.
   always_comb begin
      is_absj      = instruction_holding_register[15:8] == IFP_OP_ABSJ;
      is_relj      = instruction_holding_register[15:11] == IFP_OP_RELJ;
      is_mul       = instruction_holding_register[15:10] == IFP_OP_MUL;
      is_movlw     = instruction_holding_register[15:8] == IFP_OP_MOVLW;
      is_stall     = instruction_holding_register[15:8] == IFP_STALL_CODE;
      // A continuation word only acts right behind its first word.
      is_lone_cont = (instruction_holding_register[15:12] == IFP_CONT_TAG) && !prev_multi;
      exec_valid   = (state == IFP_RUN) && !is_lone_cont;
      rel_disp     = {{(IFP_PC_W-12){instruction_holding_register[10]}},
                      instruction_holding_register[10:0], 1'b0};
      next_target  = exec_pc + rel_disp;
      abs_target   = {12'h000, instruction_holding_register[7:0], 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte fetch: low byte in phase zero at the even address, high byte in phase one.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_addr <= IFP_PC_RESET;
      end else if (q == IFP_Q_FETCH) begin
         prog_addr <= {program_counter[IFP_PC_W-1:1], 1'b1};
      end else if (cycle_end && exec_valid && is_absj) begin
         // The target must be on the bus before the flush cycle fetches its low byte.
         prog_addr <= abs_target;
      end else if (cycle_end && exec_valid && is_relj) begin
         prog_addr <= {next_target[IFP_PC_W-1:1], 1'b0};
      end else begin
         prog_addr <= {program_counter[IFP_PC_W-1:1], 1'b0};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_low <= 8'h00;
      end else if (q == IFP_Q_FETCH && state != IFP_HOLD) begin
         fetch_low <= prog_rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_word <= IFP_NOP_WORD;
      end else if (q == IFP_Q_READ && state != IFP_HOLD) begin
         // A held fetch keeps its word, since the counter has already moved past it.
         fetch_word <= {prog_rdata, fetch_low};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter: stepped as the low byte is taken at the end of phase zero, loaded by jumps.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         program_counter <= IFP_PC_RESET;
      end else if (cycle_end && exec_valid && is_absj) begin
         program_counter <= abs_target;
      end else if (cycle_end && exec_valid && is_relj) begin
         program_counter <= {next_target[IFP_PC_W-1:1], 1'b0};
      end else if (q == IFP_Q_FETCH && state != IFP_HOLD) begin
         program_counter <= program_counter + IFP_PC_STEP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         exec_pc <= IFP_PC_RESET;
      end else if (cycle_end) begin
         exec_pc <= program_counter;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pipeline control state.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= IFP_RUN;
         hold_count <= 8'h00;
         fetch_hold <= 1'b0;
      end else if (cycle_end) begin
         unique case (state)
            IFP_RUN: begin
               if (exec_valid && (is_absj || is_relj)) begin
                  state <= IFP_FLUSH;
               end else if (exec_valid && is_stall) begin
                  state <= IFP_HOLD;
                  hold_count <= 8'(STALL_CYCLES);
                  fetch_hold <= 1'b1;
               end
            end
            IFP_ABS_WAIT: begin
               state <= IFP_RUN;
            end
            IFP_FLUSH: begin
               state <= IFP_RUN;
            end
            IFP_HOLD: begin
               if (hold_count <= 8'h01) begin
                  state <= IFP_RUN;
                  fetch_hold <= 1'b0;
               end else begin
                  hold_count <= hold_count - 8'h01;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holding register latched at the start of the execution cycle.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         instruction_holding_register <= IFP_NOP_WORD;
         prev_multi <= 1'b0;
      end else if (cycle_end && !(state == IFP_RUN && exec_valid && is_stall)
                   && !(state == IFP_HOLD && hold_count > 8'h01)) begin
         if (state == IFP_RUN && exec_valid && (is_absj || is_relj)) begin
            instruction_holding_register <= IFP_NOP_WORD;
            prev_multi <= 1'b0;
         end else begin
            instruction_holding_register <= fetch_word;
            prev_multi <= exec_valid && is_absj;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data memory operand read in phase one; data memory is never written back.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_addr <= 12'h000;
      end else begin
         data_addr <= {4'h0, instruction_holding_register[7:0]};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_rd <= 1'b0;
      end else begin
         data_rd <= exec_valid && is_mul && (q == IFP_Q_FETCH);
      end
   end

   // No instruction of this block writes data memory yet.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_wr <= 1'b0;
      end else begin
         data_wr <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_wdata <= 8'h00;
      end else begin
         data_wdata <= 8'h00;
      end
   end

   // The operand is taken while the read strobe still stands.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         operand <= 8'h00;
      end else if (q == IFP_Q_READ) begin
         operand <= data_rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         working_register <= 8'h00;
      end else if (cycle_end && exec_valid && is_movlw) begin
         working_register <= instruction_holding_register[7:0];
      end
   end

   // The product pair only moves on a multiply, so software may read it later.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         product_high_byte <= 8'h00;
         product_low_byte <= 8'h00;
      end else if (q == IFP_Q_WRITE && exec_valid && is_mul) begin
         product_high_byte <= product[15:8];
         product_low_byte <= product[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 2'h0;
      end else begin
         phase <= (q == 2'h3) ? 2'h0 : q + 2'h1;
      end
   end
endmodule

/* File: tb/ifp_core_monitor.sv */
// Concurrent checks on the ports of the fetch pipeline.
`timescale 1ns/10ps
module ifp_core_monitor
   import ifp_pkg::*;
#(
   parameter int STALL_CYCLES = 1
) (
   // Watched ports.
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [20:0] prog_addr,
   input wire logic [7:0]  prog_rdata,
   input wire logic [11:0] data_addr,
   input wire logic        data_rd,
   input wire logic [7:0]  data_rdata,
   input wire logic        data_wr,
   input wire logic [7:0]  data_wdata,
   input wire logic [20:0] program_counter,
   input wire logic [15:0] instruction_holding_register,
   input wire logic [7:0]  working_register,
   input wire logic [7:0]  product_high_byte,
   input wire logic [7:0]  product_low_byte,
   input wire logic [1:0]  phase,
   input wire logic        fetch_hold
);
   logic [1:0] live;

   // Phase history is only trusted two edges after reset lets go.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) live <= 2'h0;
      else live <= {live[0], 1'b1};
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////
   a_phase_steps: assert property (live[1] |-> phase == $past(phase) + 2'h1)
      else $error("phase did not step by one");
   a_pc_even: assert property (program_counter[0] == 1'b0)
      else $error("program counter bit zero set");
   a_low_even: assert property (phase == IFP_Q_FETCH |-> prog_addr[0] == 1'b0)
      else $error("low byte not at even address");
   a_byte_order: assert property (live[1] && phase == IFP_Q_READ |-> prog_addr == $past(prog_addr) + 21'h1)
      else $error("high byte not at next odd address");
   a_ir_latch: assert property ($changed(instruction_holding_register) |-> phase == IFP_Q_FETCH)
      else $error("holding register changed mid cycle");
   a_product_register_pair_by_mul: assert property ($changed({product_high_byte, product_low_byte}) |->
      phase == IFP_Q_FETCH && $past(instruction_holding_register[15:10]) == IFP_OP_MUL)
      else $error("product changed without a multiply");
   a_read_in_exec: assert property (data_rd |-> phase == IFP_Q_READ && instruction_holding_register[15:10] == IFP_OP_MUL)
      else $error("data read outside execution of a multiply");
   a_no_write: assert property (!data_wr)
      else $error("unexpected data write");
   a_hold_frozen: assert property (fetch_hold && $past(fetch_hold) |->
      $stable(program_counter) && $stable(instruction_holding_register))
      else $error("fetch moved while held");
endmodule

bind ifp_core ifp_core_monitor #(.STALL_CYCLES(STALL_CYCLES)) u_monitor (
   .sys_clk(sys_clk), .rst_b(rst_b), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
   .data_addr(data_addr), .data_rd(data_rd), .data_rdata(data_rdata), .data_wr(data_wr),
   .data_wdata(data_wdata), .program_counter(program_counter),
   .instruction_holding_register(instruction_holding_register), .working_register(working_register),
   .product_high_byte(product_high_byte), .product_low_byte(product_low_byte), .phase(phase),
   .fetch_hold(fetch_hold));

/* File: tb/ifp_mem_model.sv */
// Program and data memory seen by the fetch pipeline.
`timescale 1ns/10ps
module ifp_mem_model (
   // Program memory.
   input wire logic [20:0] prog_addr,
   output logic [7:0]      prog_rdata,
   // Data memory.
   input wire logic        sys_clk,
   input wire logic [11:0] data_addr,
   input wire logic        data_rd,
   output logic [7:0]      data_rdata
);
   logic [7:0] pmem [0:255];
   logic [7:0] last;

   initial begin
      last = 8'h00;
      for (int i = 0; i < 256; i++) pmem[i] = 8'h00;
   end

   // Byte wide store, low byte of a word at the even address.
   task automatic put_word(input int unsigned wa, input logic [15:0] w);
      pmem[(2 * wa) % 256] = w[7:0];
      pmem[(2 * wa + 1) % 256] = w[15:8];
   endtask

   assign prog_rdata = pmem[prog_addr[7:0]];
   // An unread data bus shows the inverse of its last value, so a stale sample is caught.
   assign data_rdata = data_rd ? (data_addr[7:0] ^ 8'hA5) : ~last;

   always @(posedge sys_clk) begin
      if (data_rd) last <= data_rdata;
   end
endmodule

/* File: tb/instruction_fetch_pipeline_test.sv */
// Self-checking bench for the fetch pipeline.
`timescale 1ns/10ps
module instruction_fetch_pipeline_test;
   import ifp_pkg::*;
   logic        sys_clk, rst_b, data_rd, data_wr, fetch_hold, arm, seen_bad;
   logic [20:0] prog_addr, program_counter;
   logic [7:0]  prog_rdata, data_rdata, data_wdata, working_register, product_high_byte, product_low_byte;
   logic [11:0] data_addr;
   logic [15:0] instruction_holding_register;
   logic [1:0]  phase;
   int          miscompares, checks_done;

   ifp_core #(.STALL_CYCLES(1)) uut (
      .sys_clk(sys_clk), .rst_b(rst_b), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .data_addr(data_addr), .data_rd(data_rd), .data_rdata(data_rdata), .data_wr(data_wr),
      .data_wdata(data_wdata), .program_counter(program_counter),
      .instruction_holding_register(instruction_holding_register), .working_register(working_register),
      .product_high_byte(product_high_byte), .product_low_byte(product_low_byte), .phase(phase),
      .fetch_hold(fetch_hold));
   ifp_mem_model pm (
      .prog_addr(prog_addr), .prog_rdata(prog_rdata), .sys_clk(sys_clk), .data_addr(data_addr),
      .data_rd(data_rd), .data_rdata(data_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [15:0] expect_product_register_pair(input logic [7:0] a, input logic [7:0] f);
      return 16'(a) * 16'(f ^ 8'hA5);
   endfunction

   task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait for a word to reach the holding register.
   task automatic wait_ir(input logic [15:0] w);
      for (int n = 0; n < 40 && instruction_holding_register !== w; n++) begin
         @(posedge sys_clk);
         #1;
      end
      cmp(instruction_holding_register, w);
   endtask

   task report_and_stop;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (arm && working_register === 8'hAA) seen_bad <= 1'b1;
   end

   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      $display("BAD t=%0t watchdog expired", $time);
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] lit [6];
      logic [7:0] fa [6];
      int         wp;
      miscompares = 0;
      checks_done = 0;
      rst_b = 1'b0;
      arm = 1'b0;
      seen_bad = 1'b0;
      void'($urandom(5));
      // Let the memory model clear itself before the program is written.
      #1;
      wp = 0;
      // Corner cases first: full-scale unsigned product, then a zero factor.
      for (int n = 0; n < 6; n++) begin
         lit[n] = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
         fa[n] = (n == 0) ? 8'h5A : 8'($urandom);
         pm.put_word(wp++, {IFP_OP_MOVLW, lit[n]});
         pm.put_word(wp++, {IFP_OP_MUL, 2'h0, fa[n]});
         if (n == 0) pm.put_word(wp++, 16'hF123);
      end
      pm.put_word(wp++, {IFP_STALL_CODE, 8'h00});
      pm.put_word(wp++, {IFP_OP_ABSJ, 8'h40});
      pm.put_word(wp++, {IFP_CONT_TAG, 12'h000});
      pm.put_word(wp++, {IFP_OP_MOVLW, 8'hAA});
      pm.put_word(32'h40, {IFP_OP_MOVLW, 8'h55});
      // Branch from the word after 0x41 by three words; the skipped words must not run.
      pm.put_word(32'h41, {IFP_OP_RELJ, 11'h003});
      for (int k = 32'h42; k < 32'h45; k++) pm.put_word(k, {IFP_OP_MOVLW, 8'hAA});
      pm.put_word(32'h45, {IFP_OP_MOVLW, 8'h3C});
      repeat (5) @(posedge sys_clk);
      cmp(program_counter, IFP_PC_RESET);
      cmp({product_high_byte, product_low_byte}, 21'h0);
      #1 rst_b = 1'b1;
      for (int n = 0; n < 6; n++) begin
         wait_ir({IFP_OP_MOVLW, lit[n]});
         wait_ir({IFP_OP_MUL, 2'h0, fa[n]});
         cmp(working_register, lit[n]);
         repeat (4) @(posedge sys_clk);
         #1 cmp({product_high_byte, product_low_byte}, expect_product_register_pair(lit[n], fa[n]));
         if (n == 0) begin
            wait_ir(16'hF123);
            repeat (4) @(posedge sys_clk);
            #1 cmp({product_high_byte, product_low_byte}, 21'h0FE01);
            cmp(working_register, 8'hFF);
         end
      end
      wait_ir({IFP_STALL_CODE, 8'h00});
      for (int n = 0; n < 8 && fetch_hold !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      cmp(fetch_hold, 1'b1);
      arm = 1'b1;
      for (int n = 0; n < 60 && working_register !== 8'h55; n++) begin
         @(posedge sys_clk);
         #1;
      end
      cmp(working_register, 8'h55);
      for (int n = 0; n < 60 && working_register !== 8'h3C; n++) begin
         @(posedge sys_clk);
         #1;
      end
      cmp(working_register, 8'h3C);
      cmp(seen_bad, 1'b0);
      report_and_stop;
   end
endmodule
